//--- include/mrc_defs.svh
`ifndef MRC_DEFS_SVH
`define MRC_DEFS_SVH

// Register byte offsets
`define MRC_ADDR_CTRL 8'h00
`define MRC_ADDR_SPEED 8'h04
`define MRC_ADDR_ACCEL 8'h08
`define MRC_ADDR_DECEL 8'h0c
`define MRC_ADDR_STATUS 8'h10
`define MRC_ADDR_ALARM 8'h14

// Control register fields
`define MRC_CTRL_DECEL_EN 0
`define MRC_CTRL_COAST 1
`define MRC_CTRL_HZ60 2
`define MRC_CTRL_TEST 3
`define MRC_CTRL_BRK_REL 4
`define MRC_CTRL_RESET 5'h01

// Reset values of the settings
`define MRC_SPEED_RESET 11'h12c
`define MRC_ACCEL_RESET 8'h05
`define MRC_DECEL_RESET 8'h05

// Speed limits in r/min, ramp limits in 0.1 s
`define MRC_SPD_MIN_DEC 11'h12c
`define MRC_SPD_MIN_NODEC 11'h05a
`define MRC_SPD_MAX_50 11'h578
`define MRC_SPD_MAX_60 11'h640
`define MRC_SPD_TEST 11'h12c
`define MRC_TIME_MIN_DEC 11'h002
`define MRC_TIME_MIN_NODEC 11'h000
`define MRC_TIME_MAX 11'h096

// Alarm codes
`define MRC_ALM_NONE 8'h00
`define MRC_ALM_POWER_ON 8'h2e

// Timing
`define MRC_CLK_NS 5
`define MRC_TICK_NS 100000
`define MRC_DEB_NS 1000000

`endif

//--- include/mrc_pkg.sv
package mrc_pkg;

	typedef enum logic [2:0] {
		MRC_ST_INIT = 3'b000,
		MRC_ST_IDLE = 3'b001,
		MRC_ST_RUN = 3'b010,
		MRC_ST_DECEL = 3'b011,
		MRC_ST_COAST = 3'b100,
		MRC_ST_ALARM = 3'b101
	} mrc_state_type;

endpackage : mrc_pkg

//--- src/mrc_debounce.sv
module mrc_debounce #(
	parameter logic [17:0] DEB_CYC = 18'd200000
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic raw_in,
	output logic level_out
);

	logic sync1_r;
	logic sync2_r;
	logic level_r;
	logic [17:0] cnt_r;

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			level_r <= 1'b0;
			cnt_r <= 18'h0;
		end
		else if (clk_en)
		begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r;
			// Level only follows after a full stable window
			if (sync2_r == level_r)
				cnt_r <= 18'h0;
			else if (cnt_r == DEB_CYC - 18'd1)
			begin
				level_r <= sync2_r; // R20
				cnt_r <= 18'h0;
			end
			else
				cnt_r <= cnt_r + 18'd1;
		end
	end

	assign level_out = level_r;

	stable_window_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R20
		(clk_en && $changed(level_r)) |-> ($past(cnt_r) == DEB_CYC - 18'd1))
		else $error("debounced level changed before stable window");

endmodule : mrc_debounce

//--- src/mrc_ramp.sv
`include "mrc_defs.svh"

module mrc_ramp #(
	parameter logic [14:0] TICK_CYC = 15'(`MRC_TICK_NS / `MRC_CLK_NS)
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic zero,
	input wire logic [10:0] target,
	input wire logic [7:0] accel_time,
	input wire logic [7:0] decel_time,
	output logic [10:0] speed
);

	logic [14:0] tick_cnt_r;
	logic [7:0] step_cnt_r;
	logic [10:0] speed_r;
	logic tick;
	logic going_up;
	logic [7:0] period;
	logic step;

	// One tick per 100 us; a period of N ticks per r/min gives N*0.1 s per 1000 r/min
	assign tick = (tick_cnt_r == TICK_CYC - 15'd1);
	assign going_up = (speed_r < target);
	assign period = going_up ? accel_time : decel_time;
	assign step = tick && (step_cnt_r + 8'd1 >= period);

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tick_cnt_r <= 15'h0;
			step_cnt_r <= 8'h0;
			speed_r <= 11'h0;
		end
		else if (clk_en)
		begin
			tick_cnt_r <= tick ? 15'h0 : tick_cnt_r + 15'd1;
			if (zero)
			begin
				speed_r <= 11'h0;
				step_cnt_r <= 8'h0;
			end
			else if (period == 8'h0)
				speed_r <= target; // Zero ramp time jumps at once
			else if (speed_r == target)
				step_cnt_r <= 8'h0;
			else if (step)
			begin
				step_cnt_r <= 8'h0;
				speed_r <= going_up ? speed_r + 11'd1 : speed_r - 11'd1;
			end
			else if (tick)
				step_cnt_r <= step_cnt_r + 8'd1;
		end
	end

	assign speed = speed_r;

endmodule : mrc_ramp

//--- src/mrc_top.sv
// Contract
// R1 - Forward input alone runs motor forward
// R2 - Reverse input alone runs motor reverse
// R3 - Starting input released: ramp down to standstill
// R4 - Both inputs active: instantaneous stop
// R5 - Both inactive: decel stop, or coast by setting
// R6 - Run input at power-up raises alarm 46
// R7 - Controller keeps run inputs off before power-up
// R8 - Test operation runs at fixed 300 r/min
// R9 - Test operation refused while brake-free active
// R10 - Panel brake release only at standstill
// R11 - Input polarity switch selects sink or source
// R12 - Decel control on: speed 300 to 1400/1600
// R13 - Decel control off: lowest speed drops to 90
// R14 - Decel control on: ramp times 0.2 to 15.0 s
// R15 - Decel control off also widens ramp range
// R16 - Controller powers up first, down last
// R17 - Brake-free releases brake, ignores runs, coasts motor
// R18 - Fault-clear input resets pending alarm
// R19 - Fault output closed normally, opens on alarm
// R20 - Run inputs synchronised and debounced before decode
`include "mrc_defs.svh"

module mrc_top #(
	parameter logic [14:0] TICK_CYC = 15'(`MRC_TICK_NS / `MRC_CLK_NS),
	parameter logic [17:0] DEB_CYC = 18'(`MRC_DEB_NS / `MRC_CLK_NS)
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic forward_run_input,
	input wire logic reverse_run_input,
	input wire logic brake_free_input,
	input wire logic fault_clear_input,
	input wire logic input_polarity_switch,
	output logic drive_en,
	output logic drive_fwd,
	output logic [10:0] speed_cmd,
	output logic brake_release,
	output logic fault_output,
	output logic [7:0] alarm_code
);

	////////////////////////////////////////////////////////////////////////////////
	// Input conditioning

	logic [3:0] pin_vec;
	logic [3:0] act_raw;
	logic [3:0] act;
	logic fwd_a;
	logic rev_a;
	logic free_a;
	logic clr_a;

	assign pin_vec = {fault_clear_input, brake_free_input, reverse_run_input, forward_run_input};
	// Sink (switch low) means a pin pulled low is on
	assign act_raw = pin_vec ^ {4{~input_polarity_switch}}; // R11

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_deb
			mrc_debounce #(.DEB_CYC(DEB_CYC)) u_deb ( // R20
				.clk_sys(clk_sys),
				.arst_n(arst_n),
				.clk_en(clk_en),
				.raw_in(act_raw[gi]),
				.level_out(act[gi])
			);
		end
	endgenerate

	assign fwd_a = act[0];
	assign rev_a = act[1];
	assign free_a = act[2];
	assign clr_a = act[3];

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [4:0] ctrl_r;
	logic [10:0] speed_set_r;
	logic [7:0] accel_r;
	logic [7:0] decel_r;
	logic [31:0] prdata_r;
	logic [31:0] rd_mux;
	logic hit;
	logic wr_acc;
	logic wr_ctrl;
	logic wr_speed;
	logic wr_accel;
	logic wr_decel;
	logic [31:0] status;
	logic standstill;

	function automatic logic [10:0] mrc_clamp(input logic [10:0] v, input logic [10:0] lo,
		input logic [10:0] hi);
		if (v < lo)
			mrc_clamp = lo;
		else if (v > hi)
			mrc_clamp = hi;
		else
			mrc_clamp = v;
	endfunction : mrc_clamp

	logic dec_en;
	logic [10:0] spd_lo;
	logic [10:0] spd_hi;
	logic [10:0] t_lo;
	logic [10:0] speed_eff;
	logic [7:0] accel_eff;
	logic [7:0] decel_eff;
	logic [10:0] accel_wide;
	logic [10:0] decel_wide;

	// Settings are kept raw and limited on use, so a later mode change re-limits them
	assign dec_en = ctrl_r[`MRC_CTRL_DECEL_EN];
	assign spd_lo = dec_en ? `MRC_SPD_MIN_DEC : `MRC_SPD_MIN_NODEC; // R12 R13
	assign spd_hi = ctrl_r[`MRC_CTRL_HZ60] ? `MRC_SPD_MAX_60 : `MRC_SPD_MAX_50; // R12 R13
	assign t_lo = dec_en ? `MRC_TIME_MIN_DEC : `MRC_TIME_MIN_NODEC; // R14 R15
	assign speed_eff = mrc_clamp(speed_set_r, spd_lo, spd_hi);
	assign accel_wide = mrc_clamp({3'h0, accel_r}, t_lo, `MRC_TIME_MAX); // R14 R15
	assign decel_wide = mrc_clamp({3'h0, decel_r}, t_lo, `MRC_TIME_MAX); // R14 R15
	assign accel_eff = accel_wide[7:0];
	assign decel_eff = decel_wide[7:0];

	always_comb
	begin
		hit = 1'b1;
		if (paddr == `MRC_ADDR_CTRL)
			rd_mux = {27'h0, ctrl_r};
		else if (paddr == `MRC_ADDR_SPEED)
			rd_mux = {21'h0, speed_eff};
		else if (paddr == `MRC_ADDR_ACCEL)
			rd_mux = {24'h0, accel_eff};
		else if (paddr == `MRC_ADDR_DECEL)
			rd_mux = {24'h0, decel_eff};
		else if (paddr == `MRC_ADDR_STATUS)
			rd_mux = status;
		else if (paddr == `MRC_ADDR_ALARM)
			rd_mux = {24'h0, alarm_code};
		else
		begin
			rd_mux = 32'h0;
			hit = 1'b0;
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign wr_acc = psel && penable && pwrite && hit;
	assign wr_ctrl = wr_acc && (paddr == `MRC_ADDR_CTRL);
	assign wr_speed = wr_acc && (paddr == `MRC_ADDR_SPEED);
	assign wr_accel = wr_acc && (paddr == `MRC_ADDR_ACCEL);
	assign wr_decel = wr_acc && (paddr == `MRC_ADDR_DECEL);

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_r <= `MRC_CTRL_RESET;
			speed_set_r <= `MRC_SPEED_RESET;
			accel_r <= `MRC_ACCEL_RESET;
			decel_r <= `MRC_DECEL_RESET;
			prdata_r <= 32'h0;
		end
		else if (clk_en)
		begin
			// Read data is caught in the setup cycle, so no wait state is needed
			if (psel && !penable)
				prdata_r <= rd_mux;
			if (wr_ctrl)
			begin
				ctrl_r[3:0] <= pwdata[3:0];
				ctrl_r[`MRC_CTRL_BRK_REL] <= pwdata[`MRC_CTRL_BRK_REL] && standstill; // R10
			end
			else if (!standstill)
				ctrl_r[`MRC_CTRL_BRK_REL] <= 1'b0; // R10
			if (wr_speed)
				speed_set_r <= pwdata[10:0];
			if (wr_accel)
				accel_r <= pwdata[7:0];
			if (wr_decel)
				decel_r <= pwdata[7:0];
		end
	end

	assign prdata = prdata_r;

	////////////////////////////////////////////////////////////////////////////////
	// Run sequencer

	mrc_pkg::mrc_state_type state_r;
	mrc_pkg::mrc_state_type state_nxt;
	logic dir_r;
	logic dir_nxt;
	logic test_r;
	logic test_nxt;
	logic [7:0] alarm_r;
	logic [7:0] alarm_nxt;
	logic [17:0] chk_cnt_r;
	logic chk_done;
	logic clr_d_r;
	logic clr_rise;
	logic fault_r;
	logic moving;
	logic ramp_zero;
	logic [10:0] target;
	logic start_off;

	// Wait until the debouncers have seen a full window before judging the power-on level
	assign chk_done = (chk_cnt_r == DEB_CYC + 18'd4);
	assign clr_rise = clr_a && !clr_d_r;
	assign start_off = test_r ? !ctrl_r[`MRC_CTRL_TEST] : (dir_r ? !fwd_a : !rev_a);
	assign moving = (state_r == mrc_pkg::MRC_ST_RUN) || (state_r == mrc_pkg::MRC_ST_DECEL);
	assign ramp_zero = !moving;
	assign target = (state_r != mrc_pkg::MRC_ST_RUN) ? 11'h0 :
		(test_r ? `MRC_SPD_TEST : speed_eff); // R8 R12 R13
	assign standstill = !moving && (state_r != mrc_pkg::MRC_ST_COAST) && (speed_cmd == 11'h0);

	always_comb
	begin
		state_nxt = state_r;
		dir_nxt = dir_r;
		test_nxt = test_r;
		alarm_nxt = alarm_r;
		case (state_r)
			mrc_pkg::MRC_ST_INIT:
				if (chk_done)
				begin
					if (fwd_a || rev_a)
					begin
						state_nxt = mrc_pkg::MRC_ST_ALARM; // R6
						alarm_nxt = `MRC_ALM_POWER_ON; // R6
					end
					else
						state_nxt = mrc_pkg::MRC_ST_IDLE;
				end
			mrc_pkg::MRC_ST_IDLE:
				if (free_a)
					state_nxt = mrc_pkg::MRC_ST_IDLE; // R17 R9
				else if (fwd_a && !rev_a)
				begin
					state_nxt = mrc_pkg::MRC_ST_RUN; // R1
					dir_nxt = 1'b1;
					test_nxt = 1'b0;
				end
				else if (rev_a && !fwd_a)
				begin
					state_nxt = mrc_pkg::MRC_ST_RUN; // R2
					dir_nxt = 1'b0;
					test_nxt = 1'b0;
				end
				else if (!fwd_a && !rev_a && ctrl_r[`MRC_CTRL_TEST])
				begin
					state_nxt = mrc_pkg::MRC_ST_RUN; // R8
					dir_nxt = 1'b1;
					test_nxt = 1'b1;
				end
			mrc_pkg::MRC_ST_RUN:
				if (free_a)
					state_nxt = mrc_pkg::MRC_ST_COAST; // R17
				else if (fwd_a && rev_a)
					state_nxt = mrc_pkg::MRC_ST_IDLE; // R4
				else if (start_off)
					state_nxt = (ctrl_r[`MRC_CTRL_COAST] && !fwd_a && !rev_a) ?
						mrc_pkg::MRC_ST_COAST : mrc_pkg::MRC_ST_DECEL; // R3 R5
			mrc_pkg::MRC_ST_DECEL:
				if (free_a)
					state_nxt = mrc_pkg::MRC_ST_COAST; // R17
				else if ((fwd_a && rev_a) || speed_cmd == 11'h0)
					state_nxt = mrc_pkg::MRC_ST_IDLE; // R4 R3
			mrc_pkg::MRC_ST_COAST:
				if (!free_a)
					state_nxt = mrc_pkg::MRC_ST_IDLE;
			mrc_pkg::MRC_ST_ALARM:
				if (clr_rise)
				begin
					state_nxt = mrc_pkg::MRC_ST_IDLE; // R18
					alarm_nxt = `MRC_ALM_NONE;
				end
			default:
				state_nxt = mrc_pkg::MRC_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= mrc_pkg::MRC_ST_INIT;
			dir_r <= 1'b1;
			test_r <= 1'b0;
			alarm_r <= `MRC_ALM_NONE;
			chk_cnt_r <= 18'h0;
			clr_d_r <= 1'b0;
			fault_r <= 1'b1;
		end
		else if (clk_en)
		begin
			state_r <= state_nxt;
			dir_r <= dir_nxt;
			test_r <= test_nxt;
			alarm_r <= alarm_nxt;
			clr_d_r <= clr_a;
			fault_r <= (state_nxt != mrc_pkg::MRC_ST_ALARM); // R19
			if (!chk_done)
				chk_cnt_r <= chk_cnt_r + 18'd1;
		end
	end

	mrc_ramp #(.TICK_CYC(TICK_CYC)) u_ramp (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.zero(ramp_zero),
		.target(target),
		.accel_time(accel_eff),
		.decel_time(decel_eff),
		.speed(speed_cmd)
	);

	assign drive_en = moving;
	assign drive_fwd = dir_r;
	// Brake holds unless driving, freed, or released from the panel at rest
	assign brake_release = free_a || moving || (ctrl_r[`MRC_CTRL_BRK_REL] && standstill); // R17 R10
	assign fault_output = fault_r;
	assign alarm_code = alarm_r;
	assign status = {5'h0, speed_cmd, 6'h0, free_a, rev_a, fwd_a, brake_release, drive_en,
		dir_r, test_r, state_r};

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n || !clk_en);

	fwd_start_a: assert property (state_r == mrc_pkg::MRC_ST_IDLE && fwd_a && !rev_a && !free_a // R1
		|=> state_r == mrc_pkg::MRC_ST_RUN && drive_en && drive_fwd)
		else $error("forward input did not start forward run");
	rev_start_a: assert property (state_r == mrc_pkg::MRC_ST_IDLE && rev_a && !fwd_a && !free_a // R2
		|=> state_r == mrc_pkg::MRC_ST_RUN && drive_en && !drive_fwd)
		else $error("reverse input did not start reverse run");
	decel_entry_a: assert property (state_r == mrc_pkg::MRC_ST_RUN && !test_r && !free_a // R3
		&& (fwd_a ^ rev_a) ##1 state_r == mrc_pkg::MRC_ST_RUN && !fwd_a && !rev_a && !free_a
		&& !ctrl_r[`MRC_CTRL_COAST] |=> state_r == mrc_pkg::MRC_ST_DECEL)
		else $error("released run input did not ramp down");
	inst_stop_a: assert property (moving && fwd_a && rev_a && !free_a // R4
		|=> !drive_en ##1 speed_cmd == 11'h0)
		else $error("both inputs did not stop at once");
	coast_cfg_a: assert property (state_r == mrc_pkg::MRC_ST_RUN && !test_r && !fwd_a && !rev_a // R5
		&& !free_a && ctrl_r[`MRC_CTRL_COAST] |=> state_r == mrc_pkg::MRC_ST_COAST)
		else $error("coast setting not honoured");
	power_alarm_a: assert property (state_r == mrc_pkg::MRC_ST_INIT && chk_done && (fwd_a || rev_a) // R6
		|=> alarm_code == `MRC_ALM_POWER_ON && !fault_output && !drive_en)
		else $error("power-on interlock alarm missing");
	test_speed_a: assert property (state_r == mrc_pkg::MRC_ST_RUN && test_r // R8
		|-> target == `MRC_SPD_TEST)
		else $error("test run not at fixed speed");
	test_refuse_a: assert property (state_r == mrc_pkg::MRC_ST_IDLE && free_a // R9 R17
		|=> state_r != mrc_pkg::MRC_ST_RUN)
		else $error("run started while brake-free active");
	panel_brake_a: assert property (ctrl_r[`MRC_CTRL_BRK_REL] |-> $past(standstill)) // R10
		else $error("panel brake release while moving");
	speed_range_a: assert property (speed_eff >= `MRC_SPD_MIN_NODEC // R12 R13
		&& speed_eff <= spd_hi && (!dec_en || speed_eff >= `MRC_SPD_MIN_DEC))
		else $error("speed setting out of range");
	ramp_range_a: assert property (dec_en |-> accel_eff >= 8'h02 && decel_eff >= 8'h02 // R14 R15
		&& accel_eff <= 8'h96 && decel_eff <= 8'h96)
		else $error("ramp time out of range");
	free_coast_a: assert property (state_r == mrc_pkg::MRC_ST_RUN && free_a // R17
		|=> state_r == mrc_pkg::MRC_ST_COAST && brake_release && !drive_en)
		else $error("brake-free did not coast");
	alarm_clear_a: assert property (state_r == mrc_pkg::MRC_ST_ALARM && clr_rise // R18 R19
		|=> state_r == mrc_pkg::MRC_ST_IDLE ##1 fault_output)
		else $error("fault clear did not reset alarm");

	fwd_run_c: cover property (state_r == mrc_pkg::MRC_ST_RUN && drive_fwd && !test_r);
	rev_run_c: cover property (state_r == mrc_pkg::MRC_ST_RUN && !drive_fwd);
	alarm_c: cover property (state_r == mrc_pkg::MRC_ST_ALARM ##1 state_r == mrc_pkg::MRC_ST_IDLE);
	test_run_c: cover property (state_r == mrc_pkg::MRC_ST_RUN && test_r);
	coast_c: cover property (state_r == mrc_pkg::MRC_ST_COAST);

endmodule : mrc_top

//--- testbench/mrc_ctl_model.sv
module mrc_ctl_model (
	input wire logic polarity,
	input wire logic fwd_req,
	input wire logic rev_req,
	input wire logic free_req,
	input wire logic clr_req,
	output logic forward_run_input,
	output logic reverse_run_input,
	output logic brake_free_input,
	output logic fault_clear_input
);
	timeunit 1ns;
	timeprecision 100ps;
	// Sink contacts pull the pin low when on, source contacts drive it high
	assign forward_run_input = fwd_req ~^ polarity;
	assign reverse_run_input = rev_req ~^ polarity;
	assign brake_free_input = free_req ~^ polarity;
	assign fault_clear_input = clr_req ~^ polarity;
endmodule : mrc_ctl_model

//--- testbench/mrc_top_test.sv
`include "mrc_defs.svh"

module mrc_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, polarity, err;
	logic fwd_req, rev_req, free_req, clr_req, fwd_pin, rev_pin, free_pin, clr_pin;
	logic drive_en, drive_fwd, brake_release, fault_output;
	logic [7:0] paddr, alarm_code;
	logic [10:0] speed_cmd, held;
	logic clk_en;
	logic [31:0] pwdata, prdata, rd;
	int failures, comparisons, k, cycles;

	mrc_top #(.TICK_CYC(15'd4), .DEB_CYC(18'd4)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.forward_run_input(fwd_pin), .reverse_run_input(rev_pin),
		.brake_free_input(free_pin), .fault_clear_input(clr_pin),
		.input_polarity_switch(polarity), .drive_en(drive_en), .drive_fwd(drive_fwd),
		.speed_cmd(speed_cmd), .brake_release(brake_release), .fault_output(fault_output),
		.alarm_code(alarm_code));

	mrc_ctl_model mdl_u (.polarity(polarity), .fwd_req(fwd_req), .rev_req(rev_req),
		.free_req(free_req), .clr_req(clr_req), .forward_run_input(fwd_pin),
		.reverse_run_input(rev_pin), .brake_free_input(free_pin), .fault_clear_input(clr_pin));

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////
	task automatic give_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// Extra idle edge at the end keeps back-to-back calls from double driving psel
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		apb(1'b1, a, d);
		apb(1'b0, a, 32'h0);
		chk("register readback", e, rd);
	endtask : wr_rd

	////////////////////////////////////////
	task automatic t_power;
		for (k = 0; k < 100 && alarm_code !== 8'h2e; k++) @(posedge clk_sys);
		chk("alarm_code", 32'h2e, alarm_code);
		chk("fault_output", 32'h0, fault_output);
		chk("drive_en", 32'h0, drive_en);
		apb(1'b0, `MRC_ADDR_ALARM, 32'h0);
		chk("alarm register", 32'h2e, rd);
		apb(1'b0, `MRC_ADDR_STATUS, 32'h0);
		chk("status in alarm", 32'h95, rd);
		fwd_req <= 1'b0;
		repeat (20) @(posedge clk_sys);
		clr_req <= 1'b1;
		repeat (20) @(posedge clk_sys);
		clr_req <= 1'b0;
		chk("alarm_code", 32'h0, alarm_code);
		chk("fault_output", 32'h1, fault_output);
		$display("test power_alarm done");
	endtask : t_power

	task automatic t_regs;
		apb(1'b0, `MRC_ADDR_CTRL, 32'h0);
		chk("ctrl reset", 32'h1, rd);
		chk("mapped error", 32'h0, err);
		apb(1'b0, `MRC_ADDR_SPEED, 32'h0);
		chk("speed reset", 32'h12c, rd);
		apb(1'b0, `MRC_ADDR_ACCEL, 32'h0);
		chk("accel reset", 32'h5, rd);
		wr_rd(`MRC_ADDR_SPEED, 32'h7d0, 32'h578);
		wr_rd(`MRC_ADDR_CTRL, 32'h5, 32'h5);
		wr_rd(`MRC_ADDR_SPEED, 32'h7d0, 32'h640);
		wr_rd(`MRC_ADDR_SPEED, 32'h0a, 32'h12c);
		wr_rd(`MRC_ADDR_CTRL, 32'h4, 32'h4);
		wr_rd(`MRC_ADDR_SPEED, 32'h0a, 32'h5a);
		wr_rd(`MRC_ADDR_ACCEL, 32'h0, 32'h0);
		wr_rd(`MRC_ADDR_CTRL, 32'h1, 32'h1);
		wr_rd(`MRC_ADDR_ACCEL, 32'h1, 32'h2);
		wr_rd(`MRC_ADDR_DECEL, 32'hc8, 32'h96);
		wr_rd(`MRC_ADDR_DECEL, 32'h2, 32'h2);
		wr_rd(`MRC_ADDR_SPEED, 32'h12c, 32'h12c);
		apb(1'b1, 8'h18, 32'hffff);
		chk("unmapped write error", 32'h1, err);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped error", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		$display("test registers done");
	endtask : t_regs

	task automatic t_forward;
		fwd_req <= 1'b1;
		repeat (2) @(posedge clk_sys);
		fwd_req <= 1'b0;
		repeat (30) @(posedge clk_sys);
		chk("drive_en after glitch", 32'h0, drive_en);
		fwd_req <= 1'b1;
		for (k = 0; k < 30 && drive_en !== 1'b1; k++) @(posedge clk_sys);
		chk("drive_en", 32'h1, drive_en);
		chk("drive_fwd", 32'h1, drive_fwd);
		// Enable low must freeze the ramp mid-way
		repeat (40) @(posedge clk_sys);
		clk_en <= 1'b0;
		@(posedge clk_sys);
		held = speed_cmd;
		repeat (40) @(posedge clk_sys);
		chk("speed_cmd frozen", held, speed_cmd);
		chk("drive_en frozen", 32'h1, drive_en);
		clk_en <= 1'b1;
		for (k = 0; k < 4000 && speed_cmd !== 11'h12c; k++) @(posedge clk_sys);
		chk("speed_cmd", 32'h12c, speed_cmd);
		fwd_req <= 1'b0;
		repeat (40) @(posedge clk_sys);
		chk("drive_en in ramp", 32'h1, drive_en);
		chk("ramping", 32'h1, speed_cmd < 11'h12c && speed_cmd != 11'h0);
		for (k = 0; k < 4000 && drive_en !== 1'b0; k++) @(posedge clk_sys);
		chk("speed_cmd stopped", 32'h0, speed_cmd);
		$display("test forward done");
	endtask : t_forward

	task automatic t_reverse;
		polarity <= 1'b1;
		repeat (20) @(posedge clk_sys);
		rev_req <= 1'b1;
		for (k = 0; k < 30 && drive_en !== 1'b1; k++) @(posedge clk_sys);
		chk("drive_en", 32'h1, drive_en);
		chk("drive_fwd", 32'h0, drive_fwd);
		repeat (100) @(posedge clk_sys);
		fwd_req <= 1'b1;
		for (k = 0; k < 15 && drive_en !== 1'b0; k++) @(posedge clk_sys);
		repeat (2) @(posedge clk_sys);
		chk("drive_en both", 32'h0, drive_en);
		chk("speed_cmd both", 32'h0, speed_cmd);
		fwd_req <= 1'b0;
		rev_req <= 1'b0;
		repeat (20) @(posedge clk_sys);
		polarity <= 1'b0;
		repeat (20) @(posedge clk_sys);
		$display("test reverse done");
	endtask : t_reverse

	task automatic t_coast;
		apb(1'b1, `MRC_ADDR_CTRL, 32'h3);
		fwd_req <= 1'b1;
		repeat (100) @(posedge clk_sys);
		fwd_req <= 1'b0;
		for (k = 0; k < 15 && drive_en !== 1'b0; k++) @(posedge clk_sys);
		chk("drive_en coast", 32'h0, drive_en);
		apb(1'b1, `MRC_ADDR_CTRL, 32'h1);
		repeat (20) @(posedge clk_sys);
		$display("test coast done");
	endtask : t_coast

	task automatic t_testop;
		apb(1'b1, `MRC_ADDR_SPEED, 32'h3e8);
		free_req <= 1'b1;
		repeat (20) @(posedge clk_sys);
		apb(1'b1, `MRC_ADDR_CTRL, 32'h9);
		repeat (50) @(posedge clk_sys);
		chk("drive_en free", 32'h0, drive_en);
		free_req <= 1'b0;
		for (k = 0; k < 30 && drive_en !== 1'b1; k++) @(posedge clk_sys);
		chk("drive_en test", 32'h1, drive_en);
		for (k = 0; k < 4000 && speed_cmd !== 11'h12c; k++) @(posedge clk_sys);
		repeat (100) @(posedge clk_sys);
		chk("speed_cmd test", 32'h12c, speed_cmd);
		apb(1'b1, `MRC_ADDR_CTRL, 32'h1);
		for (k = 0; k < 4000 && drive_en !== 1'b0; k++) @(posedge clk_sys);
		$display("test test_operation done");
	endtask : t_testop

	task automatic t_brake;
		apb(1'b1, `MRC_ADDR_CTRL, 32'h11);
		chk("brake_release panel", 32'h1, brake_release);
		apb(1'b1, `MRC_ADDR_CTRL, 32'h1);
		chk("brake_release held", 32'h0, brake_release);
		fwd_req <= 1'b1;
		for (k = 0; k < 30 && drive_en !== 1'b1; k++) @(posedge clk_sys);
		apb(1'b1, `MRC_ADDR_CTRL, 32'h11);
		apb(1'b0, `MRC_ADDR_CTRL, 32'h0);
		chk("panel release moving", 32'h0, rd[4]);
		free_req <= 1'b1;
		for (k = 0; k < 15 && drive_en !== 1'b0; k++) @(posedge clk_sys);
		chk("drive_en free", 32'h0, drive_en);
		chk("brake_release free", 32'h1, brake_release);
		repeat (50) @(posedge clk_sys);
		chk("drive_en ignored", 32'h0, drive_en);
		fwd_req <= 1'b0;
		free_req <= 1'b0;
		repeat (30) @(posedge clk_sys);
		$display("test brake done");
	endtask : t_brake

	////////////////////////////////////////
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			failures++;
			give_verdict();
		end
	end

	initial
	begin
		arst_n = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		polarity = 1'b0;
		// Run input left on across power-up on purpose to trip the interlock
		fwd_req = 1'b1;
		rev_req = 1'b0;
		free_req = 1'b0;
		clr_req = 1'b0;
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_power();
		t_regs();
		t_forward();
		t_reverse();
		t_coast();
		t_testop();
		t_brake();
		give_verdict();
	end
endmodule : mrc_top_test
